/* dv/host_spi_wake_notify_tb_top.sv */
`timescale 1ns/1ps
module host_spi_wake_notify_tb_top;
    import spi_wake_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, lfsr_reg;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        cs_wake_n, sclk, mosi, miso, miso_oe, ready_int_out, supply_enable_out, seen;
    logic [7:0]  rb;
    logic [31:0] exp_q[$];  // Expected results, oldest first
    logic [31:0] got_q[$];  // Results seen at the outputs
    int          bad_count, total_checks, cyc, lead, width, i;
    logic [15:0] ck;        // Expected checksum of the program bytes

    always #25 hclk = ~hclk;

    host_spi_wake_notify dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cs_wake_n(cs_wake_n),
        .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .ready_int_out(ready_int_out), .supply_enable_out(supply_enable_out));
    spi_host_model host_u (.cs_wake_n(cs_wake_n), .sclk(sclk), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe), .ready_int_out(ready_int_out));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Frame word with even parity over the bits the port checks
    function automatic logic [15:0] frame(input logic w, input logic [5:0] a, input logic [7:0] d);
        return {w, a, ^{w, a, d}, d};
    endfunction
    task automatic note(input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask
    // Single AHB word transfer; read data taken at the data phase end
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1 && cyc < 30000);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && cyc < 30000);
        r = hrdata;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
        ahb(1'b0, a, 32'h0, rd);
        note(e, rd & m);
    endtask
    task automatic swr(input logic [5:0] a, input logic [7:0] d, input logic bad);
        host_u.xfer(frame(1'b1, a, d) ^ {7'h00, bad, 8'h00}, rb);
    endtask
    task automatic srd(input logic [5:0] a, input logic [7:0] e);
        host_u.xfer(frame(1'b0, a, 8'h00), rb);
        note({24'h0, e}, {24'h0, rb});
    endtask
    task automatic final_report();
        repeat (2) @(posedge hclk);
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Compare each result with the oldest note
    always @(posedge hclk) begin
        while (got_q.size() > 0) begin
            total_checks++;
            if (got_q.pop_front() !== exp_q.pop_front()) begin
                bad_count++;
                $display("[ERR] %0t result %0d differs", $time, total_checks);
            end
        end
    end
    // Hang guard, well above the expected run length
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        lfsr_reg = 32'h19f51c3d;
        ck = 16'h0000;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // Data-ready cause with its enable still off must not notify
        ahb(1'b1, {24'h0, A_EVENT_TRIG}, 32'h1, rd);
        rd_chk(A_BLOCK_STATE, 32'h0, 32'hff);
        note(32'h0, {31'h0, hresp});
        rd_chk(32'h40, 32'h0, 32'hffffffff);
        repeat (3) @(posedge hclk);
        host_u.wake(seen);
        note(32'h1, {31'h0, seen});
        swr(P_ENABLES, 8'h11, 1'b0);
        swr(P_ENABLES, 8'hff, 1'b1);
        srd(P_ENABLES, 8'h11);
        note(32'h0, {31'h0, miso_oe});
        rd_chk(32'h28, 32'h11, 32'hff);
        // Program bytes written from one side and read from the other
        for (i = 0; i < 4; i++) begin
            lfsr_reg = lfsr(lfsr_reg);
            ck[8 * (i % 2) +: 8] ^= lfsr_reg[7:0] ^ lfsr_reg[15:8];
            swr(6'h20 + 6'(i), lfsr_reg[7:0], 1'b0);
            rd_chk(32'h80 + 32'(4 * i), {24'h0, lfsr_reg[7:0]}, 32'hff);
            ahb(1'b1, 32'h90 + 32'(4 * i), {24'h0, lfsr_reg[15:8]}, rd);
            srd(6'h24 + 6'(i), lfsr_reg[15:8]);
        end
        ahb(1'b1, {24'h0, A_SENSOR_STAT}, 32'h5a, rd);
        srd(P_SENSOR, 8'h5a);
        // Data-ready event with supply lead enabled
        ahb(1'b1, {24'h0, A_EVENT_TRIG}, 32'h1, rd);
        lead = 0;
        width = 0;
        repeat (1000) if (ready_int_out !== 1'b1) @(negedge hclk) lead += int'(supply_enable_out);
        note(32'h1, {31'h0, lead >= int'(SUPPLY_CYC) - 1});
        while (ready_int_out === 1'b1 && width < 1000) @(negedge hclk) width++;
        note({20'h0, PULSE_CYC}, 32'(width));
        srd(P_STATUS, 8'h03);
        swr(P_COMMAND, 8'h01, 1'b0);
        srd(P_STATUS, 8'h00);
        note(32'h0, {31'h0, supply_enable_out});
        swr(P_TEST, TM_KEY1, 1'b0);
        swr(P_TEST, TM_KEY2, 1'b0);
        rd_chk(A_BLOCK_STATE, 32'h04, 32'h04);
        rd_chk(A_BLOCK_STATE, 32'h40, 32'he0);
        // Checksum over a fully written program memory, against a wrong reference
        for (i = 8; i < 32; i++) ahb(1'b1, 32'h80 + 32'(4 * i), 32'h0, rd);
        ahb(1'b1, {24'h0, A_CKSUM_REF}, {16'h0, ~ck}, rd);
        swr(P_COMMAND, 8'h02, 1'b0);
        srd(P_CKSUM_LO, ck[7:0]);
        srd(P_CKSUM_HI, ck[15:8]);
        rd_chk(A_BLOCK_STATE, 32'h10, 32'h18);
        rd_chk({24'h0, A_CKSUM_REF}, {16'h0, ~ck}, 32'hffff);
        host_u.half_ns = 600; // Slow host
        srd(P_ENABLES, 8'h11);
        host_u.half_ns = 200;
        repeat (int'(IDLE_CYC) + 100) @(posedge hclk);
        rd_chk(A_BLOCK_STATE, 32'h00, 32'he0);
        final_report();
    end
endmodule

/* dv/spi_host_model.sv */
`timescale 1ns/1ps
// Host side of the link: makes the serial clock only inside frames
module spi_host_model (
    // Link pins
    output logic      cs_wake_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic miso_oe,
    input  wire logic ready_int_out
);
    int   half_ns = 200; // Half link period; a larger value gives a slow host
    logic last_bit;      // Last level seen on the return line

    // Idle levels before any frame
    initial begin
        cs_wake_n = 1'b1;
        sclk      = 1'b0; // Clock rests low
        mosi      = 1'b0;
        last_bit  = 1'b0;
    end

    // Pull the wake line low and wait a bounded time for the ready level
    task automatic wake(output logic seen);
        seen = 1'b0;
        cs_wake_n = 1'b0;
        // A pulled line that nobody drives high reads as idle
        repeat (400) if (!seen) #50 seen = (ready_int_out === 1'b1);
        cs_wake_n = 1'b1; // Raise again before the first frame
        #1000;
    endtask

    // One frame of 16 clocks, first bit first; returns the reply byte
    task automatic xfer(input logic [15:0] word, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        #17 cs_wake_n = 1'b0;
        for (i = 15; i >= 0; i--) begin
            mosi = word[i];         // Changes only while the clock is low
            #(half_ns) sclk = 1'b1;
            // A line nobody drives reads as noise, not as its last value
            last_bit = miso_oe ? miso : ~last_bit;
            if (i < 8) rx[i] = last_bit;
            #(half_ns) sclk = 1'b0;
        end
        #(2 * half_ns) cs_wake_n = 1'b1;
        mosi = ~mosi; // Released data line does not keep its level
        #600;
    endtask
endmodule

/* src/host_spi_wake_notify.sv */
`timescale 1ns/1ps
module host_spi_wake_notify
    import spi_wake_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial link pins
    input  wire logic        cs_wake_n,
    input  wire logic        sclk,
    input  wire logic        mosi,
    output logic             miso,
    output logic             miso_oe,
    // Host notification pins
    output logic             ready_int_out,
    output logic             supply_enable_out
);
    // Pin synchronisers; stage 0 is read only by stage 1
    // Two flops of delay per edge cap the usable serial clock well below hclk/2
    logic [2:0] sclk_sync;
    logic [1:0] cs_sync;
    logic [1:0] mosi_sync;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sclk_sync <= 3'h0;
            cs_sync   <= 2'h3;
            mosi_sync <= 2'h0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk};                                   // R02
            cs_sync   <= {cs_sync[0], cs_wake_n};
            mosi_sync <= {mosi_sync[0], mosi};
        end
    end

    pstate_t     state_reg;                // Power state
    logic        cs_q_reg;                 // Select delayed for edges
    logic [4:0]  bit_cnt_reg;              // Bits taken this frame
    logic [15:0] shin_reg;                 // Incoming frame
    logic [7:0]  shout_reg;                // Outgoing byte
    logic        miso_reg;
    logic        pending_reg;              // event_pending_flag
    logic [4:0]  cause_reg;                // pcd, fw, st, meas, dr
    enables_t    enables_reg;
    logic [7:0]  sensor_status_reg;
    logic [7:0]  sample_period_sel;
    logic [15:0] ckref_reg;
    logic [15:0] ckres_reg;                // Last checksum result
    logic [15:0] ckacc_reg;
    logic [4:0]  ckidx_reg;
    logic        ckbusy_reg;
    logic        test_mode_reg;
    logic        tm_seq_reg;
    logic [11:0] timer_reg;                // Supply lead and pulse width
    logic [11:0] idle_reg;                 // Quiet time in run
    logic [7:0]  prog_mem [PROG_BYTES];    // Program memory bytes
    logic        ah_wr_reg;
    logic [7:0]  ah_addr_reg;

    // Serial edge and frame decode; ignored entirely while asleep
    wire         port_en     = (state_reg != ST_SLEEP);                            // R16
    wire         cs_low      = ~cs_sync[1];
    wire         frame_start = port_en & cs_q_reg & cs_low;                        // R19
    wire         frame_end   = port_en & ~cs_q_reg & ~cs_low;                      // R19
    wire         sclk_rise   = port_en & cs_low & sclk_sync[1] & ~sclk_sync[2];    // R03
    wire         sclk_fall   = port_en & cs_low & ~sclk_sync[1] & sclk_sync[2];    // R03
    wire spi_cmd_t cmd       = shin_reg[15:8];
    wire         cmd_par_ok  = ~^shin_reg[15:8];
    wire         frm_par_ok  = ~^shin_reg;                                         // R04
    wire         frame_write = frame_end & (bit_cnt_reg == FRAME_BITS) & cmd.write & frm_par_ok; // R19
    wire [7:0]   wdat        = shin_reg[7:0];
    wire         wr_port     = frame_write & (cmd.addr[5:3] == S_PORT_PAGE);
    wire         wr_prog     = frame_write & (cmd.addr[5] == S_PROG_PAGE);         // R05
    wire         ack_write   = wr_port & (cmd.addr[2:0] == P_COMMAND) & wdat[CMD_ACK_BIT];     // R12
    wire         ck_start    = wr_port & (cmd.addr[2:0] == P_COMMAND) & wdat[CMD_CKSUM_BIT] & ~ckbusy_reg;
    wire         cmd_done    = sclk_rise & (bit_cnt_reg == CMD_BITS - 5'h01);
    wire [15:0]  next_in     = {shin_reg[14:0], mosi_sync[1]};

    // Port registers as seen by both masters
    wire [7:0]   status_byte = {2'h0, cause_reg, pending_reg};
    wire [7:0]   port_rd [8];                                                      // R06
    assign port_rd[0] = status_byte;
    assign port_rd[1] = 8'h00;
    assign port_rd[2] = {3'h0, enables_reg};
    assign port_rd[3] = sensor_status_reg;
    assign port_rd[4] = ckres_reg[7:0];
    assign port_rd[5] = ckres_reg[15:8];
    assign port_rd[6] = {7'h00, test_mode_reg};
    assign port_rd[7] = sample_period_sel;
    // Read data for a command, zero on bad parity or a hole in the map
    // At the eighth rise the command byte sits in the low half of the shifter
    wire [5:0]   rd_addr = next_in[6:1];
    wire         rd_par  = ~^next_in[7:0];
    wire [7:0]   spi_rdata = !rd_par ? 8'h00 :
                             rd_addr[5] ? prog_mem[rd_addr[4:0]] :
                             (rd_addr[5:3] == S_PORT_PAGE) ? port_rd[rd_addr[2:0]] : 8'h00;     // R05

    // Serial shifter: sample on rise, drive on fall
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_q_reg    <= 1'b1;
            bit_cnt_reg <= 5'h00;
            shin_reg    <= 16'h0000;
            shout_reg   <= 8'h00;
            miso_reg    <= 1'b0;
        end else begin
            cs_q_reg <= ~cs_low;
            if (frame_start) begin
                bit_cnt_reg <= 5'h00;
                shout_reg   <= 8'h00;
                miso_reg    <= 1'b0;
            end else if (sclk_rise) begin                                          // R03
                shin_reg <= next_in;
                if (bit_cnt_reg != FRAME_BITS) begin
                    bit_cnt_reg <= bit_cnt_reg + 5'h01;
                end
                if (cmd_done) begin
                    shout_reg <= spi_rdata;                                        // R04
                end
            end else if (sclk_fall) begin                                          // R03
                miso_reg  <= shout_reg[7];
                shout_reg <= {shout_reg[6:0], 1'b0};
            end
        end
    end
    // Data line driven only inside a frame; the clock is never driven
    assign miso    = miso_reg;                                                     // R01
    assign miso_oe = port_en & cs_low;                                             // R01

    // AHB-Lite: zero wait states, always OKAY
    wire         ah_take  = hsel & htrans[1] & hready;
    wire         ah_wdone = ah_wr_reg;
    wire [7:0]   ah_rsel  = haddr[7:0];
    wire [31:0]  ah_rdata =
        (ah_rsel[7]) ? {24'h0, prog_mem[ah_rsel[6:2]]} :
        (ah_rsel[7:5] == A_PORT_PAGE) ? {24'h0, port_rd[ah_rsel[4:2]]} :
        (ah_rsel == A_BLOCK_STATE) ? {24'h0, state_reg, ckres_reg != ckref_reg, ckbusy_reg,
                                      test_mode_reg, port_en, pending_reg} :
        (ah_rsel == A_CKSUM_REF) ? {16'h0, ckref_reg} :
        (ah_rsel == A_SENSOR_STAT) ? {24'h0, sensor_status_reg} : 32'h0;
    wire         trig_wr  = ah_wdone & (ah_addr_reg == A_EVENT_TRIG) & (hwdata[3:0] != 4'h0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ah_wr_reg   <= 1'b0;
            ah_addr_reg <= 8'h00;
            hrdata      <= 32'h0;
        end else begin
            ah_wr_reg   <= ah_take & hwrite;
            ah_addr_reg <= haddr[7:0];
            if (ah_take && !hwrite) begin
                hrdata <= ah_rdata;
            end
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Notification: causes gated by their enables, except trigger bit 3 which has none
    wire         ck_fail    = ckbusy_reg & (ckidx_reg == 5'(PROG_WORDS)) & (ckacc_reg != ckref_reg);
    wire         eval_hit   = trig_wr & ((hwdata[0] & enables_reg.dr_en) |                // R13
                                         (hwdata[1] & enables_reg.meas_en) |              // R13
                                         (hwdata[2] & enables_reg.st_en) |                // R15
                                         hwdata[3]);                                      // R09
    wire         notify_req = eval_hit | (ck_fail & enables_reg.fw_en);                   // R14 R15
    wire         go_supply  = notify_req & enables_reg.supply_en;

    // Flag and configuration registers; a set beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending_reg       <= 1'b0;
            cause_reg         <= 5'h00;
            enables_reg       <= ENABLES_RST;
            sensor_status_reg <= 8'h00;
            sample_period_sel <= PERIOD_RST;
            ckref_reg         <= CKREF_RST;
            test_mode_reg     <= 1'b0;
            tm_seq_reg        <= 1'b0;
        end else begin
            pending_reg <= notify_req | (pending_reg & ~ack_write);                // R09 R20
            cause_reg   <= (ack_write ? 5'h00 : cause_reg) |
                           (trig_wr ? {hwdata[3], 1'b0, hwdata[2:0]} : 5'h00) |
                           {1'b0, ck_fail, 3'h0};
            if (wr_port && cmd.addr[2:0] == P_ENABLES) begin
                enables_reg <= enables_t'(wdat[4:0]);
            end
            if (wr_port && cmd.addr[2:0] == P_PERIOD) begin
                sample_period_sel <= wdat;
            end
            if (ah_wdone && ah_addr_reg == A_SENSOR_STAT) begin
                sensor_status_reg <= hwdata[7:0];
            end
            if (ah_wdone && ah_addr_reg == A_CKSUM_REF) begin
                ckref_reg <= hwdata[15:0];
            end
            // Two keys in a row unlock; zero locks again
            if (wr_port && cmd.addr[2:0] == P_TEST) begin                          // R07
                tm_seq_reg <= (wdat == TM_KEY1);
                if (tm_seq_reg && wdat == TM_KEY2) begin
                    test_mode_reg <= 1'b1;
                end else if (wdat == 8'h00) begin
                    test_mode_reg <= 1'b0;
                end
            end else if (frame_write) begin
                tm_seq_reg <= 1'b0;
            end
        end
    end

    // Program memory: a serial write wins over a same-cycle AHB write
    always_ff @(posedge hclk) begin
        if (wr_prog) begin
            prog_mem[cmd.addr[4:0]] <= wdat;                                       // R05
        end else if (ah_wdone && ah_addr_reg[7]) begin
            prog_mem[ah_addr_reg[6:2]] <= hwdata[7:0];
        end
    end

    // Checksum engine: one 16-bit word a cycle, then compare
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ckbusy_reg <= 1'b0;
            ckidx_reg  <= 5'h00;
            ckacc_reg  <= 16'h0000;
            ckres_reg  <= 16'h0000;
        end else if (ck_start) begin                                               // R14
            ckbusy_reg <= 1'b1;
            ckidx_reg  <= 5'h00;
            ckacc_reg  <= 16'h0000;
        end else if (ckbusy_reg) begin
            if (ckidx_reg == 5'(PROG_WORDS)) begin
                ckbusy_reg <= 1'b0;
                ckres_reg  <= ckacc_reg;                                           // R14
            end else begin
                ckacc_reg <= ckacc_reg ^ {prog_mem[{ckidx_reg[3:0], 1'b1}],
                                          prog_mem[{ckidx_reg[3:0], 1'b0}]};
                ckidx_reg <= ckidx_reg + 5'h01;
            end
        end
    end

    // Power state: wake, optional supply lead, pulse, then run until quiet
    pstate_t notify_target;
    assign notify_target = go_supply ? ST_SUPPLY : ST_PULSE;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_SLEEP;
            timer_reg <= 12'h000;
            idle_reg  <= 12'h000;
        end else begin
            // Quiet counter restarts on any select activity
            idle_reg <= (cs_low || state_reg != ST_RUN) ? IDLE_CYC : idle_reg - {11'h0, idle_reg != 12'h0};
            timer_reg <= timer_reg - {11'h0, timer_reg != 12'h0};
            case (state_reg)
                ST_SLEEP, ST_READY, ST_RUN: begin
                    if (notify_req && (state_reg != ST_READY || !frame_start)) begin  // R09
                        state_reg <= notify_target;
                        timer_reg <= go_supply ? SUPPLY_CYC - 12'h1 : PULSE_CYC - 12'h1;
                    end else if (state_reg == ST_SLEEP && cs_low) begin
                        state_reg <= ST_READY;                                     // R16 R08
                    end else if (state_reg == ST_READY && frame_start) begin
                        state_reg <= ST_RUN;                                       // R08
                    end else if (state_reg == ST_RUN && !cs_low && idle_reg == 12'h0 && !pending_reg) begin
                        state_reg <= ST_SLEEP;                                     // R10 R20
                    end
                end
                ST_SUPPLY: begin
                    if (timer_reg == 12'h0) begin
                        state_reg <= ST_PULSE;
                        timer_reg <= PULSE_CYC - 12'h1;
                    end
                end
                ST_PULSE: begin
                    if (timer_reg == 12'h0) begin
                        state_reg <= ST_RUN;                                       // R10
                    end
                end
                default: state_reg <= ST_SLEEP;
            endcase
        end
    end
    // Supply rises ahead of the pulse and holds until the event is acknowledged
    assign supply_enable_out = enables_reg.supply_en & pending_reg & port_en;      // R09
    assign ready_int_out     = (state_reg == ST_READY) | (state_reg == ST_PULSE);  // R17 R09

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_pulse_width: assert property ((state_reg == ST_PULSE) && $past(state_reg) != ST_PULSE |->  // R09
        ##99 (state_reg == ST_PULSE) ##1 (state_reg == ST_RUN)) else $error("interrupt pulse width wrong");
    a_pending_set: assert property (notify_req |=> pending_reg) else $error("pending flag not set");  // R09
    a_ack_clear: assert property (ack_write && !notify_req |=> !pending_reg) else $error("ack did not clear");  // R20
    a_bad_parity: assert property (frame_end && !frm_par_ok |=> $stable(enables_reg) && $stable(sample_period_sel))
        else $error("bad frame changed registers");  // R19
    a_supply_lead: assert property ($rose(state_reg == ST_PULSE) && enables_reg.supply_en |->  // R09
        $past(supply_enable_out, 2)) else $error("supply not ahead of pulse");
    a_wake_ready: assert property (state_reg == ST_SLEEP && cs_low && !notify_req |=> ##1 ready_int_out)
        else $error("wake did not raise ready");  // R16 R17
    a_run_hold: assert property (state_reg == ST_RUN && (cs_low || pending_reg) |=> state_reg != ST_SLEEP)
        else $error("slept during transfers");  // R10
    a_cksum_len: assert property ($rose(ckbusy_reg) |-> ckbusy_reg [*8] ##10 !ckbusy_reg)
        else $error("checksum length wrong");  // R14
    a_gate_dr: assert property (trig_wr && hwdata[3:0] == 4'h1 && !enables_reg.dr_en |-> !eval_hit)
        else $error("data-ready pulse not gated");  // R13
endmodule

/* src/spi_wake_pkg.sv */
// Contract
// R01: Client only, four wires, never drives clock
// R02: Serial clock at most 10 MHz
// R03: Clock idles low, sample rise, drive fall
// R04: 16-clock command/response frame, even parity
// R05: Host frames reach the whole memory map
// R06: Eight 8-bit port registers
// R07: Key sequence enables serial test mode
// R08: Wake low enables port, stays running
// R09: Met condition sets flag, supply, pulse
// R10: Stay running while host transfers continue
// R11: Host reads status first, then details
// R12: Host acknowledges by writing acknowledge bit
// R13: Data-ready and measurement pulses separately enabled
// R14: Commanded 16-bit XOR checksum, compare, notify
// R15: Self-test and firmware pulses need enables
// R16: Low select wakes while port disabled
// R17: Ready output asserted after host wake
// R18: Host pulls ready/interrupt line idle
// R19: Select bounds frame; bad parity changes nothing
// R20: Acknowledge clears flag, then sleep allowed
package spi_wake_pkg;
    // AHB byte offsets
    localparam logic [7:0] A_EVENT_TRIG  = 8'h00;   // W: event causes, starts evaluation
    localparam logic [7:0] A_BLOCK_STATE = 8'h04;   // R: block state
    localparam logic [7:0] A_CKSUM_REF   = 8'h08;   // RW: checksum reference
    localparam logic [7:0] A_SENSOR_STAT = 8'h0c;   // RW: sensor status
    localparam logic [2:0] A_PORT_PAGE   = 3'h1;    // haddr[7:5]: port registers 0x20..0x3c
    // Serial map (6-bit address)
    localparam logic [2:0] S_PORT_PAGE   = 3'h0;    // 0x00..0x07 port registers
    localparam logic       S_PROG_PAGE   = 1'b1;    // 0x20..0x3f program memory
    localparam logic [2:0] P_STATUS      = 3'h0;
    localparam logic [2:0] P_COMMAND     = 3'h1;
    localparam logic [2:0] P_ENABLES     = 3'h2;
    localparam logic [2:0] P_SENSOR      = 3'h3;
    localparam logic [2:0] P_CKSUM_LO    = 3'h4;
    localparam logic [2:0] P_CKSUM_HI    = 3'h5;
    localparam logic [2:0] P_TEST        = 3'h6;
    localparam logic [2:0] P_PERIOD      = 3'h7;
    // Field positions
    localparam int CMD_ACK_BIT   = 0;
    localparam int CMD_CKSUM_BIT = 1;
    // Reset values
    localparam logic [4:0]  ENABLES_RST = 5'h00;
    localparam logic [7:0]  PERIOD_RST  = 8'h00;
    localparam logic [15:0] CKREF_RST   = 16'h0000;
    // Test mode entry keys, written in turn to the test register
    localparam logic [7:0] TM_KEY1 = 8'h4d;
    localparam logic [7:0] TM_KEY2 = 8'hb2;
    // Frame
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CMD_BITS   = 5'h08;
    localparam int PROG_BYTES = 32;
    localparam int PROG_WORDS = 16;
    // Timing
    localparam int CLK_NS        = 50;
    localparam int SUPPLY_LEAD_NS = 10000;          // Supply ahead of the pulse
    localparam int INT_PULSE_NS   = 5000;           // Interrupt pulse width
    localparam int IDLE_NS        = 100000;         // Quiet time before sleeping
    localparam logic [11:0] SUPPLY_CYC = 12'((SUPPLY_LEAD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] PULSE_CYC  = 12'((INT_PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] IDLE_CYC   = 12'((IDLE_NS + CLK_NS - 1) / CLK_NS);
    // Power state
    typedef enum logic [2:0] {
        ST_SLEEP  = 3'b000,
        ST_READY  = 3'b001,
        ST_RUN    = 3'b010,
        ST_SUPPLY = 3'b011,
        ST_PULSE  = 3'b100
    } pstate_t;
    // Command byte of a frame
    typedef struct packed {
        logic       write;
        logic [5:0] addr;
        logic       parity;
    } spi_cmd_t;
    // Pulse enables
    typedef struct packed {
        logic supply_en;   // Raise supply before pulse
        logic fw_en;       // Firmware check failure
        logic st_en;       // Self-test failure
        logic meas_en;     // Measurement status not clear
        logic dr_en;       // Data ready
    } enables_t;
endpackage
